// >>> hw/mhsp_map.vh
// Constants of the modem host serial port: field positions, reset values, counts.
// Behaviour
// - Select and direction levels decode four modes
// - Mode follows select levels, never their edges
// - Port type low means SPI, high UART
// - Idle receive output follows port type level
// - UART sends async; SPI always synchronous
// - Async uses three lines; registers need sync
// - Async access drives no data clock
// - Transmit entry: idle, power up, then forward
// - Synchronous access: device drives bit clock
// - Sync receive: PLL clock, data stable rising
// - Sync receive entry: clock low, then data
// - Sync transmit: sample input on rising edge
// - Register access always synchronous, same lines
// - Register write shifts in MSB first
// - Register updates on select falling edge only
// - Normal mode keeps last 24, fewer aborts
// - Abort with sixteen or more flags write ok
// - Extended mode needs exactly 24 or 48
// - Register read MSB first, 24 bits normally
// - Extended read length chosen by bit 18
// - Receive direction keeps transmit power off
// - Bit 14 chooses sync or async UART receive
// - Unlocked PLL forces clock and data low
`ifndef MHSP_MAP_VH
`define MHSP_MAP_VH

// ----------------------------------------------------------------
// Control register layout
// ----------------------------------------------------------------
`define MHSP_CTRL_W 48
`define MHSP_CTRL_RESET 48'h000000000000
`define MHSP_BIT_SYNC_ACCESS 14
`define MHSP_BIT_RD_LEN48 18
`define MHSP_BIT_EXTENDED 21

// ----------------------------------------------------------------
// Bit counts of a register access
// ----------------------------------------------------------------
`define MHSP_CNT_W 6
`define MHSP_CNT_MAX 6'h3f
`define MHSP_BITS_SHORT 6'h18
`define MHSP_BITS_LONG 6'h30
`define MHSP_BITS_OK_MIN 6'h10

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define MHSP_CLK_HZ 40000000
`define MHSP_BAUD 4800
`define MHSP_HALF_BIT_CYCLES (`MHSP_CLK_HZ / (2 * `MHSP_BAUD))
`define MHSP_SETTLE_CYCLES 64

`endif

// >>> hw/mhsp_bit_clk_gen.v
// Half-bit tick generator for the internally made bit clock.
`default_nettype none

module mhsp_bit_clk_gen #(
    parameter HALF_CYCLES = 4166,
    parameter CW = 16
) (
    input wire clk_sys,
    input wire nrst,
    input wire run,
    output reg tick
);

    reg [CW-1:0] cnt_q;

    always @(posedge clk_sys) begin
        if (!nrst) begin
            cnt_q <= {CW{1'b0}};
            tick <= 1'b0;
        end else if (!run) begin
            // Restart so the first half period is always whole
            cnt_q <= {CW{1'b0}};
            tick <= 1'b0;
        end else if (cnt_q == HALF_CYCLES[CW-1:0] - {{(CW-1){1'b0}}, 1'b1}) begin
            cnt_q <= {CW{1'b0}};
            tick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
            tick <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// >>> hw/mhsp_port.v
// Host serial port of the power line modem: mode decode, bit clock, register access.
`include "mhsp_map.vh"
`default_nettype none

module mhsp_port #(
    parameter HALF_BIT_CYCLES = `MHSP_HALF_BIT_CYCLES,
    parameter SETTLE_CYCLES = `MHSP_SETTLE_CYCLES
) (
    input wire clk_sys,
    input wire nrst,
    input wire regDataSel,
    input wire dirSel,
    input wire hostPortTypeSel,
    input wire txSerialIn,
    input wire demodData,
    input wire demodValid,
    input wire pllClk,
    input wire pllLocked,
    output reg rxSerialOut,
    output reg bitClockOut,
    output reg registerWriteOk,
    output reg txPowerOn,
    output reg modData,
    output reg modStrobe,
    output reg [`MHSP_CTRL_W-1:0] ctrlReg
);

    // ----------------------------------------------------------------
    // Mode codes, {select, direction}
    // ----------------------------------------------------------------
    localparam [1:0] MODE_TX = 2'b00;
    localparam [1:0] MODE_RX = 2'b01;
    localparam [1:0] MODE_WR = 2'b10;
    localparam [1:0] MODE_RD = 2'b11;
    localparam SW = 16;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    reg selMeta_q;
    reg sel_q;
    reg selPrev_q;
    reg dirMeta_q;
    reg dir_q;
    reg typeMeta_q;
    reg type_q;
    reg txMeta_q;
    reg tx_q;

    always @(posedge clk_sys) begin
        if (!nrst) begin
            selMeta_q <= 1'b0;
            sel_q <= 1'b0;
            selPrev_q <= 1'b0;
            dirMeta_q <= 1'b1;
            dir_q <= 1'b1;
            typeMeta_q <= 1'b0;
            type_q <= 1'b0;
            txMeta_q <= 1'b0;
            tx_q <= 1'b0;
        end else begin
            selMeta_q <= regDataSel;
            sel_q <= selMeta_q;
            selPrev_q <= sel_q;
            dirMeta_q <= dirSel;
            dir_q <= dirMeta_q;
            typeMeta_q <= hostPortTypeSel;
            type_q <= typeMeta_q;
            txMeta_q <= txSerialIn;
            tx_q <= txMeta_q;
        end
    end

    // ----------------------------------------------------------------
    // Mode decode and settle timer
    // ----------------------------------------------------------------
    reg [1:0] mode_q;
    reg [SW-1:0] settle_q;
    wire [1:0] modeNow;
    wire modeChange;
    wire settled;
    wire selFall;
    wire uartPort;
    wire accessSync;
    wire txSync;
    wire rxSync;

    // Both lines pass equal synchronisers, so a change of both at once
    // does not show a third mode in between
    assign modeNow = {sel_q, dir_q};
    assign modeChange = (modeNow != mode_q);
    assign settled = (settle_q == {SW{1'b0}});
    assign selFall = selPrev_q & ~sel_q;
    assign uartPort = type_q;
    assign accessSync = ctrlReg[`MHSP_BIT_SYNC_ACCESS];
    // SPI forces sync both ways; UART sends only asynchronously
    assign txSync = ~uartPort;
    assign rxSync = ~uartPort | accessSync;

    always @(posedge clk_sys) begin
        if (!nrst) begin
            mode_q <= MODE_RX;
            settle_q <= SETTLE_CYCLES[SW-1:0];
        end else if (modeChange) begin
            // Any change restarts the whole wait; pins that keep moving
            // never let line data through
            mode_q <= modeNow;
            settle_q <= SETTLE_CYCLES[SW-1:0];
        end else if (!settled) begin
            settle_q <= settle_q - {{(SW-1){1'b0}}, 1'b1};
        end
    end

    // ----------------------------------------------------------------
    // Internally made bit clock
    // ----------------------------------------------------------------
    reg genClk_q;
    reg [`MHSP_CNT_W-1:0] rdLeft_q;
    wire tick;
    wire genRun;
    wire genRise;
    wire genFall;
    wire rdActive;

    // Read clock stops once the last bit has gone out
    assign rdActive = (rdLeft_q != {`MHSP_CNT_W{1'b0}});
    // Register access skips the settle wait: no line circuitry involved
    assign genRun = ~modeChange & (
        (mode_q == MODE_WR) |
        ((mode_q == MODE_RD) & rdActive) |
        ((mode_q == MODE_TX) & txSync & settled));
    assign genRise = tick & ~genClk_q;
    assign genFall = tick & genClk_q;

    mhsp_bit_clk_gen #(
        .HALF_CYCLES(HALF_BIT_CYCLES),
        .CW(16)
    ) u_clk_gen (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .run(genRun),
        .tick(tick)
    );

    always @(posedge clk_sys) begin
        if (!nrst) begin
            genClk_q <= 1'b0;
        end else if (!genRun) begin
            genClk_q <= 1'b0;
        end else if (tick) begin
            genClk_q <= ~genClk_q;
        end
    end

    // ----------------------------------------------------------------
    // Recovered clock edges
    // ----------------------------------------------------------------
    // The recovered clock is not tied to clk_sys, so it is synchronised
    // like a pin; the host sees it a few cycles after the loop makes it
    reg pllMeta_q;
    reg pllSync_q;
    reg pllPrev_q;
    wire pllFall;

    // Only the second and third stages are read, never the first
    assign pllFall = pllPrev_q & ~pllSync_q;

    always @(posedge clk_sys) begin
        if (!nrst) begin
            pllMeta_q <= 1'b0;
            pllSync_q <= 1'b0;
            pllPrev_q <= 1'b0;
        end else begin
            pllMeta_q <= pllClk;
            pllSync_q <= pllMeta_q;
            pllPrev_q <= pllSync_q;
        end
    end

    // ----------------------------------------------------------------
    // Register write shifter
    // ----------------------------------------------------------------
    reg [`MHSP_CTRL_W-1:0] wrShift_q;
    reg [`MHSP_CNT_W-1:0] wrCnt_q;
    wire extended;
    wire wrLong;
    wire wrShort;
    wire wrNormalOk;
    wire wrOkMin;

    assign extended = ctrlReg[`MHSP_BIT_EXTENDED];
    assign wrLong = (wrCnt_q == `MHSP_BITS_LONG);
    assign wrShort = (wrCnt_q == `MHSP_BITS_SHORT);
    assign wrNormalOk = (wrCnt_q >= `MHSP_BITS_SHORT);
    assign wrOkMin = (wrCnt_q >= `MHSP_BITS_OK_MIN);

    always @(posedge clk_sys) begin
        if (!nrst) begin
            wrShift_q <= `MHSP_CTRL_RESET;
            wrCnt_q <= {`MHSP_CNT_W{1'b0}};
        end else if (modeChange && modeNow == MODE_WR) begin
            wrShift_q <= `MHSP_CTRL_RESET;
            wrCnt_q <= {`MHSP_CNT_W{1'b0}};
        end else if (mode_q == MODE_WR && genRise) begin
            // Oldest bit moves up, so the last bits land lowest
            wrShift_q <= {wrShift_q[`MHSP_CTRL_W-2:0], tx_q};
            // Saturate so an overlong burst never wraps back onto
            // an accepted count of 24 or 48
            if (wrCnt_q != `MHSP_CNT_MAX) begin
                wrCnt_q <= wrCnt_q + {{(`MHSP_CNT_W-1){1'b0}}, 1'b1};
            end
        end
    end

    // ----------------------------------------------------------------
    // Control register and write outcome
    // ----------------------------------------------------------------
    // Commit waits for the select falling edge; the synchroniser
    // delay means the last bit has long been taken by then.
    always @(posedge clk_sys) begin
        if (!nrst) begin
            ctrlReg <= `MHSP_CTRL_RESET;
            registerWriteOk <= 1'b0;
        end else if (selFall && mode_q == MODE_WR) begin
            if (!extended) begin
                if (wrNormalOk) begin
                    ctrlReg[23:0] <= wrShift_q[23:0];
                    registerWriteOk <= 1'b0;
                end else begin
                    registerWriteOk <= wrOkMin;
                end
            end else if (wrLong) begin
                ctrlReg <= wrShift_q;
                registerWriteOk <= 1'b0;
            end else if (wrShort) begin
                ctrlReg[23:0] <= wrShift_q[23:0];
                registerWriteOk <= 1'b0;
            end else begin
                registerWriteOk <= wrOkMin;
            end
        end else if (modeChange && modeNow == MODE_WR) begin
            // Flag always reports the latest write access only
            registerWriteOk <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Register read shifter
    // ----------------------------------------------------------------
    reg [`MHSP_CTRL_W-1:0] rdShift_q;
    wire rdLong;

    assign rdLong = extended & ctrlReg[`MHSP_BIT_RD_LEN48];

    always @(posedge clk_sys) begin
        if (!nrst) begin
            rdShift_q <= `MHSP_CTRL_RESET;
            rdLeft_q <= {`MHSP_CNT_W{1'b0}};
        end else if (modeChange && modeNow == MODE_RD) begin
            if (rdLong) begin
                rdShift_q <= ctrlReg;
                rdLeft_q <= `MHSP_BITS_LONG;
            end else begin
                rdShift_q <= {ctrlReg[23:0], 24'h000000};
                rdLeft_q <= `MHSP_BITS_SHORT;
            end
        end else if (mode_q == MODE_RD && genFall) begin
            // Shift on falling edges so data stand still at rising ones
            rdShift_q <= {rdShift_q[`MHSP_CTRL_W-2:0], 1'b0};
            rdLeft_q <= rdLeft_q - {{(`MHSP_CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // ----------------------------------------------------------------
    // Line side and host side outputs
    // ----------------------------------------------------------------
    always @(posedge clk_sys) begin
        if (!nrst) begin
            rxSerialOut <= 1'b0;
            bitClockOut <= 1'b0;
            txPowerOn <= 1'b0;
            modData <= 1'b0;
            modStrobe <= 1'b0;
        end else begin
            modStrobe <= 1'b0;
            // Follows the decoded pins, not mode_q, so power comes up
            // while the settle wait is still running
            txPowerOn <= (modeNow == MODE_TX);
            case (mode_q)
                MODE_TX: begin
                    rxSerialOut <= type_q;
                    bitClockOut <= txSync ? genClk_q : 1'b0;
                    if (!settled || modeChange) begin
                        modData <= 1'b0;
                    end else if (txSync) begin
                        // Taken one cycle before the host sees the rise
                        if (genRise) begin
                            modData <= tx_q;
                            modStrobe <= 1'b1;
                        end
                    end else begin
                        modData <= tx_q;
                        modStrobe <= 1'b1;
                    end
                end
                MODE_RX: begin
                    if (!settled || modeChange) begin
                        bitClockOut <= 1'b0;
                        rxSerialOut <= type_q;
                    end else if (rxSync) begin
                        if (!pllLocked) begin
                            bitClockOut <= 1'b0;
                            rxSerialOut <= 1'b0;
                        end else begin
                            bitClockOut <= pllSync_q;
                            if (pllFall) begin
                                rxSerialOut <= demodValid ? demodData : type_q;
                            end
                        end
                    end else begin
                        // Host must find the bit timing on its own
                        bitClockOut <= 1'b0;
                        rxSerialOut <= demodValid ? demodData : type_q;
                    end
                end
                MODE_RD: begin
                    bitClockOut <= genClk_q;
                    // Held low after the last bit rather than showing stale data
                    rxSerialOut <= rdActive ? rdShift_q[`MHSP_CTRL_W-1] : 1'b0;
                end
                default: begin
                    bitClockOut <= genClk_q;
                    rxSerialOut <= 1'b0;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// >>> bench/mhsp_port_assertions.sv
// Pin-level checks of the modem host serial port.
`include "mhsp_map.vh"
`default_nettype none

module mhsp_port_chk #(
    parameter HALF_BIT_CYCLES = 8,
    parameter SETTLE_CYCLES = 4
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic regDataSel,
    input wire logic dirSel,
    input wire logic hostPortTypeSel,
    input wire logic txSerialIn,
    input wire logic demodValid,
    input wire logic pllLocked,
    input wire logic rxSerialOut,
    input wire logic bitClockOut,
    input wire logic registerWriteOk,
    input wire logic txPowerOn,
    input wire logic modData,
    input wire logic modStrobe,
    input wire logic [`MHSP_CTRL_W-1:0] ctrlReg
);
    timeunit 1ns;
    timeprecision 100ps;
    localparam int AgeLim = SETTLE_CYCLES + 6;
    logic [15:0] utxAge_q;
    logic [3:0] rdSeen_q;
    logic [6:0] rdCnt_q;
    logic clkPrev_q;
    wire uartTx = hostPortTypeSel && !regDataSel && !dirSel;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);

    // Read pulses are counted only once the pins have settled, since the old
    // mode may still toggle the clock for a few cycles
    always_ff @(posedge clk_sys) begin
        clkPrev_q <= bitClockOut;
        rdSeen_q <= {rdSeen_q[2:0], regDataSel && dirSel};
        utxAge_q <= (uartTx && nrst && utxAge_q != 16'hffff) ? utxAge_q + 16'h1 : 16'h0;
        if (!nrst || !rdSeen_q[3])
            rdCnt_q <= 7'h0;
        else if (bitClockOut && !clkPrev_q)
            rdCnt_q <= rdCnt_q + 7'h1;
    end

    sequence sRxHeld;
        dirSel[*6];
    endsequence
    sequence sTxHeld;
        (!regDataSel && !dirSel)[*8];
    endsequence
    sequence sSpiRxUnlocked;
        (!hostPortTypeSel && !regDataSel && dirSel && !pllLocked)[*6];
    endsequence

    chk_rx_tx_off: assert property (sRxHeld |-> !txPowerOn && !modStrobe)
        else $error("transmit path active in receive direction");
    chk_tx_power_up: assert property (sTxHeld |-> txPowerOn)
        else $error("transmit power off in transmit mode");
    chk_async_no_clk: assert property (uartTx[*8] |-> !bitClockOut)
        else $error("bit clock runs in async transmit");
    chk_unlock_low: assert property (sSpiRxUnlocked |-> !bitClockOut && !rxSerialOut)
        else $error("clock or data high while loop unlocked");
    chk_idle_level: assert property ((hostPortTypeSel && !regDataSel && dirSel && !demodValid
        && !ctrlReg[`MHSP_BIT_SYNC_ACCESS])[*6] |-> rxSerialOut)
        else $error("idle receive output not high for uart type");
    chk_commit_end: assert property (regDataSel[*6] |=> $stable(ctrlReg))
        else $error("control register changed during access");
    chk_abort_keeps: assert property ($rose(registerWriteOk) |-> $stable(ctrlReg))
        else $error("aborted write changed control register");
    chk_read_len: assert property (rdCnt_q <= ((ctrlReg[21] && ctrlReg[18]) ? 7'h30 : 7'h18))
        else $error("too many read clock pulses");
    chk_async_follow: assert property (($stable(txSerialIn) && utxAge_q > AgeLim)[*4]
        |-> modData == txSerialIn)
        else $error("async transmit data not forwarded");
endmodule

bind mhsp_port mhsp_port_chk #(
    .HALF_BIT_CYCLES(HALF_BIT_CYCLES),
    .SETTLE_CYCLES(SETTLE_CYCLES)
) uChk (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .regDataSel(regDataSel),
    .dirSel(dirSel),
    .hostPortTypeSel(hostPortTypeSel),
    .txSerialIn(txSerialIn),
    .demodValid(demodValid),
    .pllLocked(pllLocked),
    .rxSerialOut(rxSerialOut),
    .bitClockOut(bitClockOut),
    .registerWriteOk(registerWriteOk),
    .txPowerOn(txPowerOn),
    .modData(modData),
    .modStrobe(modStrobe),
    .ctrlReg(ctrlReg)
);

`default_nettype wire

// >>> bench/mhsp_host_model.sv
// Host controller model: shifts words out on the bit clock and captures reads.
`default_nettype none

module mhsp_host_model (
    input wire logic clk_sys,
    input wire logic load,
    input wire logic asyncTx,
    input wire logic [47:0] word,
    input wire logic [6:0] nBits,
    input wire logic bitClockOut,
    input wire logic rxSerialOut,
    output logic txSerialIn,
    output logic [6:0] riseCnt,
    output logic [47:0] rxWord
);
    timeunit 1ns;
    timeprecision 100ps;
    logic clkPrev;
    int idx;
    int gap;

    initial begin
        txSerialIn = 1'b0;
        riseCnt = 7'h0;
        rxWord = 48'h0;
        clkPrev = 1'b0;
        idx = 0;
        gap = 0;
    end

    always @(posedge clk_sys) begin
        clkPrev <= bitClockOut;
        if (load) begin
            txSerialIn <= word[nBits - 7'h1];
            idx <= nBits - 2;
            gap <= 0;
            riseCnt <= 7'h0;
            rxWord <= 48'h0;
        end else if (asyncTx) begin
            gap <= (gap == 9) ? 0 : gap + 1;
            if (gap == 9)
                txSerialIn <= !txSerialIn;
        end else begin
            if (bitClockOut && !clkPrev) begin
                riseCnt <= riseCnt + 7'h1;
                rxWord <= {rxWord[46:0], rxSerialOut};
            end
            // Past the last bit the line shows the inverse, never a held copy
            if (!bitClockOut && clkPrev) begin
                txSerialIn <= (idx >= 0) ? word[idx] : !txSerialIn;
                idx <= idx - 1;
            end
        end
    end
endmodule

`default_nettype wire

// >>> bench/tb_mhsp_port.sv
// Self-checking bench of the modem host serial port.
`default_nettype none
`define CHK(nm, e, g) begin nCompared++; if ((g) !== (e)) begin numErrors++; \
    $display("BAD %s exp %h got %h", nm, (e), (g)); end end

module tb_mhsp_port;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys, nrst, regDataSel, dirSel, hostPortTypeSel, txSerialIn;
    logic demodData, demodValid, pllClk, pllLocked, load, asyncTx;
    logic rxSerialOut, bitClockOut, registerWriteOk, txPowerOn, modData, modStrobe;
    logic [47:0] ctrlReg, word, expCtrl, rxWord;
    logic [6:0] nBits, riseCnt;
    int numErrors = 0;
    int nCompared = 0;
    int stbCnt = 0;

    mhsp_port #(.HALF_BIT_CYCLES(8), .SETTLE_CYCLES(4)) uut (
        .clk_sys(clk_sys), .nrst(nrst), .regDataSel(regDataSel), .dirSel(dirSel),
        .hostPortTypeSel(hostPortTypeSel), .txSerialIn(txSerialIn), .demodData(demodData),
        .demodValid(demodValid), .pllClk(pllClk), .pllLocked(pllLocked),
        .rxSerialOut(rxSerialOut), .bitClockOut(bitClockOut),
        .registerWriteOk(registerWriteOk), .txPowerOn(txPowerOn), .modData(modData),
        .modStrobe(modStrobe), .ctrlReg(ctrlReg));

    mhsp_host_model host (
        .clk_sys(clk_sys), .load(load), .asyncTx(asyncTx), .word(word), .nBits(nBits),
        .bitClockOut(bitClockOut), .rxSerialOut(rxSerialOut), .txSerialIn(txSerialIn),
        .riseCnt(riseCnt), .rxWord(rxWord));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // Recovered clock at twice the internally made bit clock rate, off the system clock's edges
    initial begin
        pllClk = 1'b0;
        #7;
        forever #100 pllClk = ~pllClk;
    end
    always @(posedge clk_sys) if (modStrobe === 1'b1) stbCnt <= stbCnt + 1;

    task automatic wrapUp();
        if (numErrors == 0 && nCompared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    task automatic waitCnt(input bit useStb, input int n);
        int k;
        for (k = 0; k < 3000 && (useStb ? stbCnt : int'(riseCnt)) < n; k++) cyc(1);
        if ((useStb ? stbCnt : int'(riseCnt)) < n) begin
            `CHK("waitDone", 1'b1, 1'b0)
            wrapUp();
        end
    endtask
    task automatic setPins(input logic s, input logic d, input logic [47:0] w, input int n);
        word = w;
        nBits = 7'(n);
        load = 1'b1;
        regDataSel = s;
        dirSel = d;
        cyc(1);
        load = 1'b0;
    endtask
    task automatic regWr(input logic [47:0] w, input int n, input logic [47:0] ev, input logic ok);
        setPins(1'b1, 1'b0, w, n);
        waitCnt(0, n);
        `CHK("ctrlHold", expCtrl, ctrlReg)
        regDataSel = 1'b0;
        dirSel = 1'b1;
        cyc(8);
        expCtrl = ev;
        `CHK("ctrlReg", expCtrl, ctrlReg)
        `CHK("writeOk", ok, registerWriteOk)
    endtask
    task automatic regRd(input int n);
        setPins(1'b1, 1'b1, 48'h0, 1);
        waitCnt(0, n);
        cyc(40);
        `CHK("rdCount", 7'(n), riseCnt)
        `CHK("rdData", (n == 48) ? expCtrl : {24'h0, expCtrl[23:0]}, rxWord)
        regDataSel = 1'b0;
        cyc(8);
    endtask
    task automatic txSpi();
        int k;
        int base;
        hostPortTypeSel = 1'b0;
        base = stbCnt;
        setPins(1'b0, 1'b0, 48'h555555555555, 48);
        for (k = 1; k <= 6; k++) begin
            waitCnt(1, base + k);
            `CHK("modData", txSerialIn, modData)
        end
        `CHK("txPower", 1'b1, txPowerOn)
    endtask
    task automatic txUart();
        int k;
        logic v;
        hostPortTypeSel = 1'b1;
        asyncTx = 1'b1;
        cyc(12);
        repeat (3) begin
            v = txSerialIn;
            for (k = 0; k < 30 && txSerialIn === v; k++) cyc(1);
            cyc(5);
            `CHK("asyncData", txSerialIn, modData)
            `CHK("asyncClk", 1'b0, bitClockOut)
        end
        asyncTx = 1'b0;
    endtask
    task automatic rxModes();
        hostPortTypeSel = 1'b0;
        setPins(1'b0, 1'b1, 48'h0, 1);
        cyc(12);
        `CHK("rxPower", 1'b0, txPowerOn)
        `CHK("unlockClk", 1'b0, bitClockOut)
        `CHK("spiIdle", 1'b0, rxSerialOut)
        hostPortTypeSel = 1'b1;
        cyc(6);
        `CHK("uartIdle", 1'b1, rxSerialOut)
        demodValid = 1'b1;
        cyc(6);
        `CHK("asyncRx", 1'b0, rxSerialOut)
        hostPortTypeSel = 1'b0;
        demodData = 1'b1;
        pllLocked = 1'b1;
        cyc(60);
        `CHK("syncClk", 1'b1, riseCnt > 7'h2)
        `CHK("syncRx", 1'b1, rxSerialOut)
        pllLocked = 1'b0;
    endtask

    initial begin
        {nrst, regDataSel, hostPortTypeSel, demodData, demodValid, pllLocked} = 6'h0;
        {load, asyncTx, dirSel} = 3'h1;
        word = 48'h0;
        nBits = 7'h1;
        expCtrl = 48'h0;
        cyc(16);
        nrst = 1'b1;
        cyc(4);
        `CHK("rstCtrl", 48'h0, ctrlReg)
        regWr(48'h123456, 24, 48'h123456, 1'b0);
        regWr(48'h30a1b2c, 26, 48'h0a1b2c, 1'b0);
        regWr(48'hfffff, 20, 48'h0a1b2c, 1'b1);
        regWr(48'h3ff, 10, 48'h0a1b2c, 1'b0);
        regWr(48'h240000, 24, 48'h240000, 1'b0);
        regWr(48'h3fffffff, 30, 48'h240000, 1'b1);
        regWr(48'ha5c30f240000, 48, 48'ha5c30f240000, 1'b0);
        regRd(48);
        regWr(48'h2c1234, 24, 48'ha5c30f2c1234, 1'b0);
        regWr(48'h041234, 24, 48'ha5c30f041234, 1'b0);
        regRd(24);
        txSpi();
        txUart();
        rxModes();
        wrapUp();
    end
endmodule

`default_nettype wire
